// [src/upf_pkg.sv]
// Constants, beat types and helpers for the upstream burst framer.
// Assumes one 250 MHz clock and a synchronous, active-high reset.
package upf_pkg;
  localparam int MEM_DEPTH     = 2048;
  localparam int PTR_W         = 11;
  localparam int LEN_W         = 14;
  localparam int SID_BYTES     = 4;
  localparam int PSP_BYTES     = 4;
  localparam int ENTRY_BYTES   = 2;
  localparam int MAX_ENTRIES   = 3;
  localparam int HDR_SEG_BYTES = 8;
  localparam int TRL_SEG_BYTES = 4;
  localparam int CRC_BYTES     = 4;
  localparam int IP_HDR_BYTES  = 20;
  localparam int OVERHEAD      = IP_HDR_BYTES + SID_BYTES + PSP_BYTES
                               + MAX_ENTRIES * ENTRY_BYTES + HDR_SEG_BYTES
                               + TRL_SEG_BYTES + CRC_BYTES;
  localparam logic [LEN_W-1:0] OVERHEAD_LEN  = LEN_W'(OVERHEAD);
  localparam logic [LEN_W-1:0] MEM_DEPTH_LEN = LEN_W'(MEM_DEPTH);
  localparam logic [31:0] CRC_INIT   = 32'hffffffff;
  localparam logic [31:0] CRC_POLY   = 32'hedb88320;
  localparam logic [15:0] LFSR_TAPS  = 16'hb400;
  localparam logic [15:0] LFSR_SEED  = 16'hace1;
  localparam logic        VCCV_BIT   = 1'b0;
  localparam logic        SEQ_VALID  = 1'b1;
  localparam logic [1:0]  EXT_HDR    = 2'b00;
  localparam logic [1:0]  FLAGS_HDR  = 2'b10;
  localparam logic [1:0]  FLAGS_PAY  = 2'b00;
  localparam logic [1:0]  FLAGS_TRL  = 2'b01;
  localparam logic [1:0]  BUF_FULL   = 2'h2;
  localparam int          NUM_PHASES = 9;

  typedef struct packed {
    logic [7:0]  data;
    logic        first;
    logic        last;
    logic        empty;
    logic [63:0] hdrSeg;
    logic [31:0] trlSeg;
  } upf_in_beat_t;

  typedef struct packed {
    logic [7:0] data;
    logic       sop;
    logic       eop;
  } upf_out_beat_t;

  typedef enum logic {S_FILL, S_EMIT} upf_state_t;
  typedef enum logic [3:0] {
    EM_SID, EM_PSP, EM_TH, EM_TP, EM_TT, EM_HDR, EM_PAY, EM_TRL, EM_CRC
  } upf_phase_t;

  function automatic logic [31:0] upf_crc_byte(input logic [31:0] c,
                                               input logic [7:0]  d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int k = 0; k < 8; k++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
endpackage

// [src/upf_framer.sv]
// Upstream burst framer for one single-carrier logical channel.
// Assumes the burst source sends well-formed bursts of one channel and
// that outer Ethernet and IP headers are added downstream.
`timescale 1ns/10ps
module upf_framer
  import upf_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          srst,
  input  wire logic [31:0]   sessionId,
  input  wire logic [2:0]    flowId,
  input  wire logic [13:0]   mtuBytes,
  input  wire upf_in_beat_t  inBeat,
  input  wire logic          inValid,
  output logic               inReady,
  output upf_out_beat_t      outBeat,
  output logic               outValid,
  input  wire logic          outReady
);

  logic [7:0]       mem [MEM_DEPTH];
  upf_state_t       state_r;
  upf_phase_t       phase_r;
  logic [LEN_W-1:0] idx_r;
  logic [LEN_W-1:0] payCnt_r;
  logic             firstPkt_r;
  logic             lastPkt_r;
  logic [63:0]      hdrSeg_r;
  logic [31:0]      trlSeg_r;
  logic [31:0]      crc_r;
  logic [15:0]      seq_r;
  logic             seqLoaded_r;
  logic [15:0]      lfsr_r;
  logic             inReady_r;
  upf_out_beat_t    buf0_r;
  upf_out_beat_t    buf1_r;
  logic [1:0]       cnt_r;
  logic             outValid_r;

  // Payload room per packet, clipped to the staging memory
  wire logic [LEN_W-1:0] capRaw  = mtuBytes - OVERHEAD_LEN;
  wire logic [LEN_W-1:0] capBytes =
    (mtuBytes <= OVERHEAD_LEN) ? LEN_W'(1) :
    (capRaw > MEM_DEPTH_LEN)   ? MEM_DEPTH_LEN : capRaw;

  // beats of this one channel only
  wire logic take = inValid & inReady_r & (state_r == S_FILL);
  wire logic [LEN_W-1:0] payInc = payCnt_r + LEN_W'(1);
  wire logic writeByte = take & ~inBeat.empty;
  // close at room or burst end, never concatenate
  wire logic fillDone = take & (inBeat.last | (writeByte &
                                 (payInc >= capBytes)));

  wire logic hasHdr = firstPkt_r;
  wire logic hasPay = payCnt_r != '0;
  wire logic hasTrl = lastPkt_r;
  // count of entries in the segment table
  wire logic [6:0] segCnt = 7'(hasHdr) + 7'(hasPay) + 7'(hasTrl);

  logic [NUM_PHASES-1:0] present;
  always_comb begin
    present                = '0;
    present[int'(EM_SID)]  = 1'b1;
    present[int'(EM_PSP)]  = 1'b1;
    present[int'(EM_TH)]   = hasHdr;
    present[int'(EM_TP)]   = hasPay;
    present[int'(EM_TT)]   = hasTrl;
    present[int'(EM_HDR)]  = hasHdr;
    present[int'(EM_PAY)]  = hasPay;
    present[int'(EM_TRL)]  = hasTrl;
    present[int'(EM_CRC)]  = 1'b1;
  end

  // next present segment, header before payload before trailer
  upf_phase_t nextPhase;
  always_comb begin
    nextPhase = EM_CRC;
    for (int p = NUM_PHASES - 1; p > 0; p--) begin
      if (p > int'(phase_r) && present[p]) begin
        nextPhase = upf_phase_t'(p);
      end
    end
  end

  function automatic logic [7:0] pickByte(input logic [63:0]      w,
                                          input int               nb,
                                          input logic [LEN_W-1:0] i);
    logic [63:0] s;
    s = w >> (8 * (nb - 1 - int'(i)));
    return s[7:0];
  endfunction

  // common header layout; reserved bits sent as zero
  wire logic [31:0] pspWord = {VCCV_BIT, SEQ_VALID, EXT_HDR, flowId, 1'b0,
                               1'b0, segCnt, seq_r};
  // header entry carries begin flag only
  wire logic [15:0] entHdr = {FLAGS_HDR, LEN_W'(HDR_SEG_BYTES)};
  // payload entry has both flags clear
  wire logic [15:0] entPay = {FLAGS_PAY, payCnt_r};
  // trailer entry carries end flag only
  wire logic [15:0] entTrl = {FLAGS_TRL, LEN_W'(TRL_SEG_BYTES)};
  wire logic [31:0] crcOut = ~crc_r;
  wire logic [31:0] crcSh  = crcOut >> {idx_r[1:0], 3'b000};

  logic [7:0]       phByte;
  logic [LEN_W-1:0] phLen;
  always_comb begin
    phByte = 8'h00;
    phLen  = LEN_W'(1);
    case (phase_r)
      EM_SID: begin
        // session identifier names channel and payload use
        phByte = pickByte({32'h00000000, sessionId}, SID_BYTES, idx_r);
        phLen  = LEN_W'(SID_BYTES);
      end
      EM_PSP: begin
        phByte = pickByte({32'h00000000, pspWord}, PSP_BYTES, idx_r);
        phLen  = LEN_W'(PSP_BYTES);
      end
      EM_TH: begin
        phByte = pickByte({48'h0, entHdr}, ENTRY_BYTES, idx_r);
        phLen  = LEN_W'(ENTRY_BYTES);
      end
      EM_TP: begin
        phByte = pickByte({48'h0, entPay}, ENTRY_BYTES, idx_r);
        phLen  = LEN_W'(ENTRY_BYTES);
      end
      EM_TT: begin
        phByte = pickByte({48'h0, entTrl}, ENTRY_BYTES, idx_r);
        phLen  = LEN_W'(ENTRY_BYTES);
      end
      EM_HDR: begin
        phByte = pickByte(hdrSeg_r, HDR_SEG_BYTES, idx_r);
        phLen  = LEN_W'(HDR_SEG_BYTES);
      end
      EM_PAY: begin
        phByte = mem[idx_r[PTR_W-1:0]];
        phLen  = payCnt_r;
      end
      EM_TRL: begin
        phByte = pickByte({32'h00000000, trlSeg_r}, TRL_SEG_BYTES, idx_r);
        phLen  = LEN_W'(TRL_SEG_BYTES);
      end
      EM_CRC: begin
        // frame check sequence, least significant byte first
        phByte = crcSh[7:0];
        phLen  = LEN_W'(CRC_BYTES);
      end
      default: begin
        phByte = 8'h00;
        phLen  = LEN_W'(1);
      end
    endcase
  end

  wire logic pop      = outValid_r & outReady;
  wire logic push     = (state_r == S_EMIT) & ((cnt_r != BUF_FULL) | pop);
  wire logic phLast   = idx_r == (phLen - LEN_W'(1));
  wire logic pktEnd   = push & phLast & (phase_r == EM_CRC);
  wire upf_out_beat_t pushBeat = '{data: phByte,
                                   sop:  (phase_r == EM_SID) &&
                                         (idx_r == '0),
                                   eop:  (phase_r == EM_CRC) && phLast};
  wire logic [1:0] cntNxt = cnt_r + 2'(push) - 2'(pop);

  upf_state_t stateNxt;
  always_comb begin
    case (state_r)
      S_FILL:  stateNxt = fillDone ? S_EMIT : S_FILL;
      S_EMIT:  stateNxt = pktEnd ? S_FILL : S_EMIT;
      default: stateNxt = S_FILL;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_r   <= S_FILL;
      inReady_r <= 1'b0;
    end else begin
      state_r   <= stateNxt;
      inReady_r <= stateNxt == S_FILL;
    end
  end

  // stage burst bytes as one payload segment per packet
  always_ff @(posedge clock) begin
    if (writeByte) begin
      mem[payCnt_r[PTR_W-1:0]] <= inBeat.data;
    end
  end

  // unit state carried across consecutive packets
  always_ff @(posedge clock) begin
    if (srst) begin
      payCnt_r   <= '0;
      firstPkt_r <= 1'b1;
      lastPkt_r  <= 1'b0;
      hdrSeg_r   <= '0;
      trlSeg_r   <= '0;
    end else if (take) begin
      // header segment opens the unit's first packet
      if (inBeat.first) begin
        hdrSeg_r   <= inBeat.hdrSeg;
        firstPkt_r <= 1'b1;
      end
      // trailer rides in the packet where the burst ends
      if (inBeat.last) begin
        trlSeg_r <= inBeat.trlSeg;
      end
      lastPkt_r <= inBeat.last;
      // an empty burst adds no payload byte
      if (writeByte) begin
        payCnt_r <= payInc;
      end
    end else if (pktEnd) begin
      // next packet starts clean; a new unit only after a last one
      payCnt_r   <= '0;
      firstPkt_r <= lastPkt_r;
      lastPkt_r  <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      phase_r <= EM_SID;
      idx_r   <= '0;
      crc_r   <= CRC_INIT;
    end else if (push) begin
      if (phase_r != EM_CRC) begin
        crc_r <= upf_crc_byte(crc_r, phByte);
      end
      if (!phLast) begin
        idx_r <= idx_r + LEN_W'(1);
      end else if (phase_r == EM_CRC) begin
        phase_r <= EM_SID;
        idx_r   <= '0;
        crc_r   <= CRC_INIT;
      end else begin
        phase_r <= nextPhase;
        idx_r   <= '0;
      end
    end
  end

  // random start from a free-running LFSR, then step per packet
  always_ff @(posedge clock) begin
    if (srst) begin
      lfsr_r      <= LFSR_SEED;
      seq_r       <= '0;
      seqLoaded_r <= 1'b0;
    end else begin
      lfsr_r <= lfsr_r[0] ? ((lfsr_r >> 1) ^ LFSR_TAPS) : (lfsr_r >> 1);
      if (!seqLoaded_r) begin
        seq_r <= lfsr_r;
      end else if (pktEnd) begin
        seq_r <= seq_r + 16'h0001;
      end
      if (state_r == S_EMIT) begin
        seqLoaded_r <= 1'b1;
      end
    end
  end

  // Two-entry output buffer absorbs a receiver stall
  always_ff @(posedge clock) begin
    if (srst) begin
      buf0_r     <= '0;
      buf1_r     <= '0;
      cnt_r      <= '0;
      outValid_r <= 1'b0;
    end else begin
      cnt_r      <= cntNxt;
      outValid_r <= cntNxt != '0;
      if (push && (cnt_r == '0 || (pop && cnt_r == 2'h1))) begin
        buf0_r <= pushBeat;
      end else if (pop) begin
        buf0_r <= buf1_r;
      end
      if (push && (cnt_r != '0) && !(pop && cnt_r == 2'h1)) begin
        buf1_r <= pushBeat;
      end
    end
  end

  assign inReady  = inReady_r;
  assign outBeat  = buf0_r;
  assign outValid = outValid_r;

  // checksum bytes are the inverted register, low byte first
  a_crc_bytes: assert property (@(posedge clock) disable iff (srst)
    push && phase_r == EM_CRC
      |-> pushBeat.data == ~crc_r[8*idx_r[1:0] +: 8])
    else $error("CRC byte mismatch");

  // fixed flag bits of the sub-layer header
  a_psp_flags: assert property (@(posedge clock) disable iff (srst)
    push && phase_r == EM_PSP && idx_r == '0
      |-> pushBeat.data[7:4] == 4'h4 && !pushBeat.data[0])
    else $error("bad sub-layer header flags");

  a_hdr_entry: assert property (@(posedge clock) disable iff (srst)
    push && phase_r == EM_TH && idx_r == '0
      |-> pushBeat.data[7:6] == 2'b10)
    else $error("header entry flags wrong");

  a_pay_entry: assert property (@(posedge clock) disable iff (srst)
    push && phase_r == EM_TP && idx_r == '0
      |-> pushBeat.data[7:6] == 2'b00)
    else $error("payload entry flags wrong");

  a_trl_entry: assert property (@(posedge clock) disable iff (srst)
    push && phase_r == EM_TT && idx_r == '0
      |-> pushBeat.data[7:6] == 2'b01)
    else $error("trailer entry flags wrong");

  // segment count matches the entries sent
  a_seg_count: assert property (@(posedge clock) disable iff (srst)
    push && phase_r == EM_PSP && idx_r == LEN_W'(1)
      |-> pushBeat.data == {1'b0, segCnt} && segCnt != '0)
    else $error("segment count wrong");

  // sequence steps by one per packet
  a_seq_step: assert property (@(posedge clock) disable iff (srst)
    pktEnd && seqLoaded_r |=> seq_r == $past(seq_r) + 16'h0001)
    else $error("sequence did not step");

  // after a unit's last packet the next one opens a new unit
  a_unit_bound: assert property (@(posedge clock) disable iff (srst)
    pktEnd && lastPkt_r |=> firstPkt_r && !lastPkt_r)
    else $error("unit boundary lost");

  a_mtu_room: assert property (@(posedge clock) disable iff (srst)
    state_r == S_EMIT |-> payCnt_r <= capBytes)
    else $error("payload exceeds MTU room");

  // an empty burst yields header and trailer only
  a_no_payload: assert property (@(posedge clock) disable iff (srst)
    take && inBeat.empty && inBeat.first && inBeat.last && payCnt_r == '0
      |=> state_r == S_EMIT && segCnt == 7'h2)
    else $error("empty burst framed wrongly");

endmodule

// [testbench/upf_core_sink.sv]
// Model of the receiving core: takes framer bytes promptly or with stalls.
// Assumes the bench judges every byte taken, so only readiness lives here.
`timescale 1ns/10ps
module upf_core_sink (
  input  wire logic clock,
  input  wire logic stallOn,
  output logic      outReady
);
  initial begin
    outReady = 1'b1;
    forever begin
      @(posedge clock);
      #1;
      outReady = stallOn ? ($urandom % 3 != 0) : 1'b1;
    end
  end
endmodule

// [testbench/upf_framer_test.sv]
// Self-checking bench for the upstream burst framer.
// Assumes the core sink model beside it and the framer package.
`timescale 1ns/10ps
module upf_framer_test
  import upf_pkg::*;
;
  logic          clock = 1'b0;
  logic          srst;
  logic [31:0]   sessionId;
  logic [2:0]    flowId;
  logic [13:0]   mtuBytes;
  upf_in_beat_t  inBeat;
  logic          inValid;
  logic          inReady;
  upf_out_beat_t outBeat;
  logic          outValid;
  logic          outReady;
  logic          stallOn;
  int            error_cnt = 0;
  int            n_checks = 0;
  int            cycles = 0;
  logic [7:0]    pay[$];
  logic [7:0]    expBytes[$];
  int            expLen[$];
  logic [7:0]    rxq[$];
  logic [15:0]   seq;
  bit            seqKnown = 1'b0;

  upf_framer dut_u (
    .clock     (clock),
    .srst      (srst),
    .sessionId (sessionId),
    .flowId    (flowId),
    .mtuBytes  (mtuBytes),
    .inBeat    (inBeat),
    .inValid   (inValid),
    .inReady   (inReady),
    .outBeat   (outBeat),
    .outValid  (outValid),
    .outReady  (outReady)
  );

  upf_core_sink sink_u (
    .clock    (clock),
    .stallOn  (stallOn),
    .outReady (outReady)
  );

  always #2 clock = ~clock;

  task automatic stop_test;
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 90000) begin
      error_cnt++;
      stop_test();
    end
  end

  function automatic logic [31:0] crcStep(logic [31:0] c, logic [7:0] d);
    c = c ^ {24'h000000, d};
    for (int k = 0; k < 8; k++) begin
      c = c[0] ? ((c >> 1) ^ 32'hedb88320) : (c >> 1);
    end
    return c;
  endfunction

  // Queues nb bytes of v, most significant first
  task automatic pushN(input logic [63:0] v, input int nb);
    for (int i = nb - 1; i >= 0; i--) begin
      expBytes.push_back(v[8*i +: 8]);
    end
  endtask

  // Expected packets of one burst; sequence and CRC filled in on arrival
  task automatic planBurst(int len, logic [63:0] hs, logic [31:0] ts);
    int room;
    int pos;
    int n;
    int hasH;
    int hasT;
    room = int'(mtuBytes) - 50;
    if (room > 2048) room = 2048;
    pos = 0;
    do begin
      n = (len - pos > room) ? room : len - pos;
      hasH = (pos == 0);
      hasT = (pos + n == len);
      pushN(64'(sessionId), 4);
      pushN({VCCV_BIT, SEQ_VALID, EXT_HDR, flowId, 1'b0}, 1);
      pushN(64'(hasH + (n > 0) + hasT), 1);
      pushN(64'h0, 2);
      if (hasH) pushN({FLAGS_HDR, 14'h0008}, 2);
      if (n > 0) pushN({FLAGS_PAY, 14'(n)}, 2);
      if (hasT) pushN({FLAGS_TRL, 14'h0004}, 2);
      if (hasH) pushN(hs, 8);
      for (int i = 0; i < n; i++) expBytes.push_back(pay[pos + i]);
      if (hasT) pushN(64'(ts), 4);
      expLen.push_back(12 + 2 * (hasH + (n > 0) + hasT) + 8 * hasH + n
                       + 4 * hasT);
      pos += n;
    end while (pos < len);
  endtask

  task automatic putBeat(upf_in_beat_t b);
    inBeat = b;
    inValid = 1'b1;
    do @(posedge clock); while (inReady !== 1'b1);
    #1;
  endtask

  task automatic sendBurst(int len, bit gaps);
    logic [63:0]  hs;
    logic [31:0]  ts;
    upf_in_beat_t b;
    hs = {$urandom, $urandom};
    ts = $urandom;
    pay.delete();
    for (int i = 0; i < len; i++) pay.push_back(8'($urandom));
    planBurst(len, hs, ts);
    for (int i = 0; i < ((len > 0) ? len : 1); i++) begin
      b = '0;
      b.data = (len > 0) ? pay[i] : 8'h00;
      b.first = (i == 0);
      b.last = (i >= len - 1);
      b.empty = (len == 0);
      b.hdrSeg = hs;
      b.trlSeg = ts;
      putBeat(b);
      if (gaps && $urandom % 4 == 0) begin
        inValid = 1'b0;
        @(posedge clock);
        #1;
      end
    end
  endtask

  task automatic drain;
    inValid = 1'b0;
    while (expLen.size() != 0) @(posedge clock);
    #1;
  endtask

  task automatic checkPacket;
    int          n;
    logic [31:0] crc;
    logic [7:0]  e;
    n = expLen.pop_front();
    if (!seqKnown) seq = {rxq[6], rxq[7]};
    seqKnown = 1'b1;
    crc = 32'hffffffff;
    check(32'(n + 20 <= int'(mtuBytes)), 32'h1);
    for (int i = 0; i < n - 4; i++) begin
      e = expBytes.pop_front();
      if (i == 6) e = seq[15:8];
      if (i == 7) e = seq[7:0];
      crc = crcStep(crc, e);
      check(32'(rxq[i]), 32'(e));
    end
    crc = ~crc;
    for (int i = 0; i < 4; i++) begin
      check(32'(rxq[n - 4 + i]), 32'(crc[8*i +: 8]));
    end
    seq++;
    rxq.delete();
  endtask

  always @(posedge clock) begin
    if (srst === 1'b0 && outValid === 1'b1 && outReady === 1'b1) begin
      if (expLen.size() == 0) begin
        check(32'h1, 32'h0);
      end else begin
        check(32'(outBeat.sop), 32'(rxq.size() == 0));
        check(32'(outBeat.eop), 32'(rxq.size() == expLen[0] - 1));
        rxq.push_back(outBeat.data);
        if (rxq.size() == expLen[0]) checkPacket();
      end
    end
  end

  initial begin
    int lens[8];
    lens = '{0, 1, 461, 462, 463, 924, 925, 0};
    void'($urandom(32'hf4af00ad));
    srst = 1'b1;
    inValid = 1'b0;
    inBeat = '0;
    stallOn = 1'b0;
    sessionId = $urandom | 32'h1;
    flowId = 3'($urandom);
    mtuBytes = 14'd512;
    repeat (12) @(posedge clock);
    #1;
    srst = 1'b0;
    stallOn = 1'b1;
    // Back-to-back bursts around the packet room boundary, then random
    foreach (lens[i]) sendBurst(lens[i], 1'b0);
    for (int i = 0; i < 5; i++) sendBurst($urandom % 1000, 1'b1);
    drain();
    mtuBytes = 14'(512 + $urandom % 1389);
    for (int i = 0; i < 3; i++) sendBurst($urandom % 1000, 1'b1);
    drain();
    // Largest burst at the largest MTU
    mtuBytes = 14'd1900;
    stallOn = 1'b0;
    sendBurst(24576, 1'b0);
    drain();
    stop_test();
  end
endmodule
